//--- design/sie_defs.svh
`ifndef SIE_DEFS_SVH
`define SIE_DEFS_SVH

// Register offsets
`define SIE_OFF_CLR       8'h00
`define SIE_OFF_SET       8'h04
`define SIE_OFF_FLAG      8'h08

// Reset values
`define SIE_RST_EN        12'h000
`define SIE_RST_FLAG      12'h000
`define SIE_RST_RDATA     32'h0000_0000

// Field positions
`define SIE_BIT_XTAL      0
`define SIE_BIT_XTAL_SLOW 1
`define SIE_BIT_RC_SLOW   2
`define SIE_BIT_RC_FAST   3
`define SIE_BIT_LOOP_RDY  4
`define SIE_BIT_LOOP_OOB  5
`define SIE_BIT_LOOP_FINE 6
`define SIE_BIT_LOOP_CRS  7
`define SIE_BIT_LOOP_RCS  8
`define SIE_BIT_BO_RDY    9
`define SIE_BIT_BO_DET    10
`define SIE_BIT_BO_SYNC   11

// Implemented width
`define SIE_NSRC          12

`endif

//--- design/sie_pkg.sv
`include "sie_defs.svh"

package sie_pkg;

	typedef logic [`SIE_NSRC-1:0] sie_src_type;

	// One-hot register select
	typedef enum logic [3:0] {
		sel_none = 4'h1,
		sel_clr  = 4'h2,
		sel_set  = 4'h4,
		sel_flag = 4'h8
	} sie_sel_type;

endpackage

//--- design/sie_flag_bank.sv
`timescale 1ns/10ps
`default_nettype none

`include "sie_defs.svh"

module sie_flag_bank #(
	parameter int NSRC = `SIE_NSRC
) (
	// Clock and reset
	input  wire logic            clk_sys,
	input  wire logic            rst_b,
	// Hardware events and software clear
	input  wire logic [NSRC-1:0] evt_set,
	input  wire logic [NSRC-1:0] sw_clr,
	// Sticky flags
	output logic      [NSRC-1:0] flag_q
);

	logic [NSRC-1:0] flag_d;

	// An event landing in the clear cycle survives
	assign flag_d = (flag_q & ~sw_clr) | evt_set;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			flag_q <= NSRC'(`SIE_RST_FLAG);
		end else begin
			flag_q <= flag_d;
		end
	end

	flag_set_wins_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(evt_set != '0) |=> ((flag_q & $past(evt_set)) == $past(evt_set)))
		else $error("event lost against flag clear");

endmodule

`default_nettype wire

//--- design/sie_top.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none

`include "sie_defs.svh"

// Summary of operation
// - Writing zero to a set-register bit leaves that enable unchanged.
// - Bit 0 enables crystal ready; bit 1 enables slow crystal ready.
// - Bits 11, 10, 9 enable brown-out sync ready, detect, ready.
// - Bit 8 enables loop reference stopped; bit 7 loop coarse lock.
// - Enabled source requests an interrupt while its pending flag is set.
// - Disabled source raises no request.
// - Enables reset to zero; enable writes refused while write protection is on.
// - Clear register shares the enables; writing one there disables.

module sie_top #(
	parameter int NSRC = `SIE_NSRC
) (
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst_b,
	// Register port
	input  wire logic [7:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [31:0]       reg_rdata,
	// Write protection of enable registers
	input  wire logic              wprot_on,
	// Source events
	input  wire sie_pkg::sie_src_type src_evt,
	// Interrupt outputs
	output sie_pkg::sie_src_type   irq_req,
	output logic                   irq
);

	import sie_pkg::*;

	// Bit views of the enable register
	logic ext_crystal_ready_en;
	logic ext_slow_crystal_ready_en;
	logic slow_rc_ready_en;
	logic fast_rc_ready_en;
	logic loop_ready_en;
	logic loop_out_of_bounds_en;
	logic loop_fine_lock_en;
	logic loop_coarse_lock_en;
	logic loop_refclk_stopped_en;
	logic brownout_ready_en;
	logic brownout_detect_en;
	logic brownout_sync_ready_en;

	sie_src_type en_q;
	sie_src_type en_d;
	sie_src_type flag_q;
	sie_src_type wbits;
	sie_src_type flag_clr;
	sie_sel_type wsel;
	sie_sel_type rsel;
	logic [31:0] rdata_d;
	logic [31:0] rdata_q;
	logic        wr_set;
	logic        wr_clr;
	logic        wr_flag;

	// Address decode shared by read and write
	function automatic sie_sel_type decode(input logic [7:0] a);
		sie_sel_type s;
		s = sel_none;
		case (a)
			`SIE_OFF_CLR:  s = sel_clr;
			`SIE_OFF_SET:  s = sel_set;
			`SIE_OFF_FLAG: s = sel_flag;
			default:       s = sel_none;
		endcase
		return s;
	endfunction

	// Zero-extend an implemented field to the bus
	function automatic logic [31:0] widen(input sie_src_type v);
		return {{(32-NSRC){1'b0}}, v};
	endfunction

	assign wsel  = decode(reg_addr);
	assign rsel  = decode(reg_addr);
	assign wbits = reg_wdata[NSRC-1:0];

	// Protection only guards the enables; flags stay clearable
	assign wr_set  = reg_wr && (wsel == sel_set) && !wprot_on;
	assign wr_clr  = reg_wr && (wsel == sel_clr) && !wprot_on;
	assign wr_flag = reg_wr && (wsel == sel_flag);

	// Ones set (set register) or clear (clear register), zeros leave the bit alone
	assign en_d = wr_set ? (en_q | wbits) :
	              wr_clr ? (en_q & ~wbits) :
	              en_q;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			en_q <= `SIE_RST_EN;
		end else begin
			en_q <= en_d;
		end
	end

	// Named bit views
	assign ext_crystal_ready_en      = en_q[`SIE_BIT_XTAL];
	assign ext_slow_crystal_ready_en = en_q[`SIE_BIT_XTAL_SLOW];
	assign slow_rc_ready_en          = en_q[`SIE_BIT_RC_SLOW];
	assign fast_rc_ready_en          = en_q[`SIE_BIT_RC_FAST];
	assign loop_ready_en             = en_q[`SIE_BIT_LOOP_RDY];
	assign loop_out_of_bounds_en     = en_q[`SIE_BIT_LOOP_OOB];
	assign loop_fine_lock_en         = en_q[`SIE_BIT_LOOP_FINE];
	assign loop_coarse_lock_en       = en_q[`SIE_BIT_LOOP_CRS];
	assign loop_refclk_stopped_en    = en_q[`SIE_BIT_LOOP_RCS];
	assign brownout_ready_en         = en_q[`SIE_BIT_BO_RDY];
	assign brownout_detect_en        = en_q[`SIE_BIT_BO_DET];
	assign brownout_sync_ready_en    = en_q[`SIE_BIT_BO_SYNC];

	// Pending flags, cleared by writing one
	assign flag_clr = wr_flag ? wbits : '0;

	sie_flag_bank #(
		.NSRC (NSRC)
	) u_flags (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.evt_set (src_evt),
		.sw_clr  (flag_clr),
		.flag_q  (flag_q)
	);

	// Requests gated by the enables
	assign irq_req = {
		brownout_sync_ready_en    & flag_q[`SIE_BIT_BO_SYNC],
		brownout_detect_en        & flag_q[`SIE_BIT_BO_DET],
		brownout_ready_en         & flag_q[`SIE_BIT_BO_RDY],
		loop_refclk_stopped_en    & flag_q[`SIE_BIT_LOOP_RCS],
		loop_coarse_lock_en       & flag_q[`SIE_BIT_LOOP_CRS],
		loop_fine_lock_en         & flag_q[`SIE_BIT_LOOP_FINE],
		loop_out_of_bounds_en     & flag_q[`SIE_BIT_LOOP_OOB],
		loop_ready_en             & flag_q[`SIE_BIT_LOOP_RDY],
		fast_rc_ready_en          & flag_q[`SIE_BIT_RC_FAST],
		slow_rc_ready_en          & flag_q[`SIE_BIT_RC_SLOW],
		ext_slow_crystal_ready_en & flag_q[`SIE_BIT_XTAL_SLOW],
		ext_crystal_ready_en      & flag_q[`SIE_BIT_XTAL]
	};
	assign irq = |irq_req;

	// Both enable views read the same state; unmapped reads zero
	assign rdata_d = !reg_rd           ? `SIE_RST_RDATA :
	                 (rsel == sel_set)  ? widen(en_q) :
	                 (rsel == sel_clr)  ? widen(en_q) :
	                 (rsel == sel_flag) ? widen(flag_q) :
	                 `SIE_RST_RDATA;

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			rdata_q <= `SIE_RST_RDATA;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	// Checks

	set_zero_keeps_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wr_set |=> ((en_q & ~$past(wbits)) == ($past(en_q) & ~$past(wbits))))
		else $error("zero written to set register changed an enable");

	crystal_bits_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(reg_wr && reg_addr == `SIE_OFF_SET && !wprot_on && reg_wdata[1:0] == 2'h3)
		|=> (ext_crystal_ready_en && ext_slow_crystal_ready_en))
		else $error("crystal enables not set");

	brownout_bits_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(reg_wr && reg_addr == `SIE_OFF_SET && !wprot_on && reg_wdata[11:9] != 3'h0)
		|=> ({brownout_sync_ready_en, brownout_detect_en, brownout_ready_en}
		     & $past(reg_wdata[11:9])) == $past(reg_wdata[11:9]))
		else $error("brown-out enables not set in order");

	loop_bits_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(reg_wr && reg_addr == `SIE_OFF_SET && !wprot_on && reg_wdata[8:7] == 2'h3)
		|=> (loop_refclk_stopped_en && loop_coarse_lock_en))
		else $error("loop enables not set");

	request_raised_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		((flag_q & en_q) != '0) |-> irq)
		else $error("enabled pending flag gave no request");

	disabled_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(en_q == '0) |-> (!irq && irq_req == '0))
		else $error("request raised with all sources disabled");

	reset_zero_a: assert property (@(posedge clk_sys)
		!rst_b |=> (en_q == '0 && reg_rdata == '0))
		else $error("enables not zero after reset");

	protect_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(reg_wr && wprot_on && reg_addr != `SIE_OFF_FLAG) |=> $stable(en_q))
		else $error("protected write changed the enables");

	clear_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wr_clr |=> ((en_q & $past(wbits)) == '0))
		else $error("clear register left an enable set");

	fine_bits_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(reg_wr && reg_addr == `SIE_OFF_SET && !wprot_on && reg_wdata[6:2] == 5'h1F)
		|=> ({loop_fine_lock_en, loop_out_of_bounds_en, loop_ready_en,
		      fast_rc_ready_en, slow_rc_ready_en} == 5'h1F))
		else $error("bits 6 to 2 not set");

	upper_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		reg_rd |=> (reg_rdata[31:12] == 20'h0_0000 &&
		            ($past(reg_addr) != `SIE_OFF_SET || reg_rdata[11:0] == $past(en_q))))
		else $error("read of set register wrong");

	// Per-bit checks catch a swapped field that the grouped ones would miss
	xtal_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(wr_set && wbits[`SIE_BIT_XTAL]) |=> ext_crystal_ready_en)
		else $error("crystal ready enable not set");

	xtal_slow_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(wr_set && wbits[`SIE_BIT_XTAL_SLOW]) |=> ext_slow_crystal_ready_en)
		else $error("slow crystal ready enable not set");

	bo_sync_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(wr_set && wbits[`SIE_BIT_BO_SYNC]) |=> brownout_sync_ready_en)
		else $error("brown-out sync ready enable not set");

	bo_detect_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(wr_set && wbits[`SIE_BIT_BO_DET]) |=> brownout_detect_en)
		else $error("brown-out detect enable not set");

	bo_ready_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(wr_set && wbits[`SIE_BIT_BO_RDY]) |=> brownout_ready_en)
		else $error("brown-out ready enable not set");

	refclk_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(wr_set && wbits[`SIE_BIT_LOOP_RCS]) |=> loop_refclk_stopped_en)
		else $error("reference stopped enable not set");

	coarse_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(wr_set && wbits[`SIE_BIT_LOOP_CRS]) |=> loop_coarse_lock_en)
		else $error("coarse lock enable not set");

	fine_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(wr_set && wbits[`SIE_BIT_LOOP_FINE]) |=> loop_fine_lock_en)
		else $error("fine lock enable not set");

	bounds_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(wr_set && wbits[`SIE_BIT_LOOP_OOB]) |=> loop_out_of_bounds_en)
		else $error("out of bounds enable not set");

	loop_ready_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(wr_set && wbits[`SIE_BIT_LOOP_RDY]) |=> loop_ready_en)
		else $error("loop ready enable not set");

	fast_rc_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(wr_set && wbits[`SIE_BIT_RC_FAST]) |=> fast_rc_ready_en)
		else $error("fast oscillator ready enable not set");

	slow_rc_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(wr_set && wbits[`SIE_BIT_RC_SLOW]) |=> slow_rc_ready_en)
		else $error("slow oscillator ready enable not set");

	// Clear side, three checks: crystal, brown-out, and loop together with the RC oscillators
	clr_crystal_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(wr_clr && wbits[1:0] != 2'h0)
		|=> (({ext_slow_crystal_ready_en, ext_crystal_ready_en} & $past(wbits[1:0])) == 2'h0))
		else $error("crystal enable survived a clear");

	clr_brownout_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(wr_clr && wbits[11:9] != 3'h0)
		|=> (({brownout_sync_ready_en, brownout_detect_en, brownout_ready_en} & $past(wbits[11:9])) == 3'h0))
		else $error("brown-out enable survived a clear");

	clr_loop_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(wr_clr && wbits[8:2] != 7'h00)
		|=> (({loop_refclk_stopped_en, loop_coarse_lock_en, loop_fine_lock_en, loop_out_of_bounds_en,
		       loop_ready_en, fast_rc_ready_en, slow_rc_ready_en} & $past(wbits[8:2])) == 7'h00))
		else $error("loop or oscillator enable survived a clear");

	set_keeps_ones_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wr_set |=> ((en_q & $past(en_q)) == $past(en_q)))
		else $error("set register write dropped an enable");

	clr_readback_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(reg_rd && reg_addr == `SIE_OFF_CLR)
		|=> (reg_rdata[11:0] == $past(en_q) && reg_rdata[31:12] == 20'h0_0000))
		else $error("read of clear register wrong");

	req_needs_en_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(irq_req & ~en_q) == '0)
		else $error("request raised for a disabled source");

	req_needs_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(irq_req & ~flag_q) == '0)
		else $error("request raised without a pending flag");

	irq_low_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		((flag_q & en_q) == '0) |-> !irq)
		else $error("interrupt line high with nothing enabled and pending");

	reset_quiet_a: assert property (@(posedge clk_sys)
		!rst_b |=> (!irq && irq_req == '0))
		else $error("request present after reset");

endmodule

`default_nettype wire

//--- sim/sie_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module sie_top_tb_top;
	import sie_pkg::*;

	logic                 clk_sys   = 1'b0;
	logic                 rst_b     = 1'b0;
	logic [7:0]           reg_addr  = 8'h00;
	logic [31:0]          reg_wdata = 32'h0000_0000;
	logic                 reg_wr    = 1'b0;
	logic                 reg_rd    = 1'b0;
	logic [31:0]          reg_rdata;
	logic                 wprot_on  = 1'b0;
	sie_src_type          src_evt   = 12'h000;
	sie_src_type          irq_req;
	logic                 irq;
	int                   fails     = 0;
	int                   checked   = 0;

	always #12.5 clk_sys = ~clk_sys;

	sie_top DUT (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.reg_wr    (reg_wr),
		.reg_rd    (reg_rd),
		.reg_rdata (reg_rdata),
		.wprot_on  (wprot_on),
		.src_evt   (src_evt),
		.irq_req   (irq_req),
		.irq       (irq)
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	// Entered and left just after a rising edge; the idle edge keeps each strobe to one assignment per step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		@(negedge clk_sys);
		chk(reg_rdata, exp, "read data");
		@(negedge clk_sys);
		chk(reg_rdata, 32'h0000_0000, "read data after its cycle");
		@(posedge clk_sys);
	endtask

	task automatic evt(input sie_src_type e);
		src_evt <= e;
		@(posedge clk_sys);
		src_evt <= 12'h000;
		@(posedge clk_sys);
	endtask

	// Sampled at the falling edge, away from the edge that launches the outputs
	task automatic chk_irq(input sie_src_type exp);
		@(negedge clk_sys);
		chk({20'h0_0000, irq_req}, {20'h0_0000, exp}, "request vector");
		chk({31'h0000_0000, irq}, {31'h0000_0000, exp != 12'h000}, "interrupt line");
		@(posedge clk_sys);
	endtask

	task automatic t_reset;
		rd_chk(8'h04, 32'h0000_0000);
		rd_chk(8'h00, 32'h0000_0000);
		chk_irq(12'h000);
		$display("test reset done");
	endtask

	task automatic t_set_bits;
		logic [31:0] exp;
		exp = 32'h0000_0000;
		for (int i = 0; i < 12; i++) begin
			wr(8'h04, 32'h0000_0001 << i);
			exp = exp | (32'h0000_0001 << i);
			rd_chk(8'h04, exp);
		end
		wr(8'h04, 32'h0000_0000);
		rd_chk(8'h04, 32'h0000_0FFF);
		wr(8'h00, 32'h0000_0FFF);
		wr(8'h04, 32'hFFFF_F000);
		rd_chk(8'h04, 32'h0000_0000);
		$display("test set bits done");
	endtask

	task automatic t_clear_prot;
		wr(8'h04, 32'h0000_0FFF);
		wprot_on <= 1'b1;
		wr(8'h00, 32'h0000_0FFF);
		rd_chk(8'h04, 32'h0000_0FFF);
		wprot_on <= 1'b0;
		wr(8'h00, 32'h0000_00F0);
		rd_chk(8'h00, 32'h0000_0F0F);
		wr(8'h00, 32'h0000_0FFF);
		wprot_on <= 1'b1;
		wr(8'h04, 32'h0000_0FFF);
		rd_chk(8'h04, 32'h0000_0000);
		wprot_on <= 1'b0;
		$display("test clear and protect done");
	endtask

	task automatic t_irq;
		evt(12'hFFF);
		chk_irq(12'h000);
		rd_chk(8'h08, 32'h0000_0FFF);
		wr(8'h04, 32'h0000_0008);
		chk_irq(12'h008);
		wr(8'h00, 32'h0000_0008);
		chk_irq(12'h000);
		wr(8'h04, 32'h0000_0800);
		chk_irq(12'h800);
		wr(8'h08, 32'h0000_0FFF);
		chk_irq(12'h000);
		rd_chk(8'h08, 32'h0000_0000);
		wr(8'h04, 32'h0000_0FFF);
		for (int i = 0; i < 12; i++) begin
			evt(12'h001 << i);
			chk_irq(12'h001 << i);
			wr(8'h08, 32'h0000_0001 << i);
			chk_irq(12'h000);
		end
		$display("test interrupt done");
	endtask

	task automatic t_unmapped;
		wr(8'h0C, 32'h0000_0000);
		wr(8'h0C, 32'h0000_0FFF);
		rd_chk(8'h0C, 32'h0000_0000);
		rd_chk(8'h04, 32'h0000_0FFF);
		$display("test unmapped done");
	endtask

	// Event and clear of the same flag in one cycle: the event wins
	task automatic t_set_wins;
		evt(12'h001);
		src_evt   <= 12'h001;
		reg_addr  <= 8'h08;
		reg_wdata <= 32'h0000_0001;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		src_evt   <= 12'h000;
		reg_wr    <= 1'b0;
		@(posedge clk_sys);
		chk_irq(12'h001);
		rd_chk(8'h08, 32'h0000_0001);
		wr(8'h08, 32'h0000_0001);
		chk_irq(12'h000);
		$display("test set against clear done");
	endtask

	task automatic t_reset_mid;
		wr(8'h04, 32'h0000_0FFF);
		evt(12'hFFF);
		chk_irq(12'hFFF);
		rst_b <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		rd_chk(8'h04, 32'h0000_0000);
		rd_chk(8'h08, 32'h0000_0000);
		chk_irq(12'h000);
		$display("test reset in run done");
	endtask

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		t_reset();
		t_set_bits();
		t_clear_prot();
		t_irq();
		t_set_wins();
		t_unmapped();
		t_reset_mid();
		complete_run();
	end
endmodule

`default_nettype wire
